// [stc_params.svh]
// Constants for the sixteen-bit timer/counter: offsets, fields, reset values, timing
//Contract
//- Run-enable bit 0 gates all counting
//- Bit 7 selects wide or byte access
//- Wide mode low read latches high byte
//- Wide mode low write loads high byte
//- Wide mode high address hits buffer only
//- Only low-byte write clears prescaler count
//- Read-only bit shows secondary clock in use
//- Two-bit prescale: 1, 2, 4, 8
//- Oscillator runs only while enable set
//- Sync bit clear synchronises external clock
//- Internal source counts per instruction cycle
//- External source counts rising edges
//- Timer, sync counter, async counter modes
//- Enabled counter forces osc pins input, read zero
//- Oscillator keeps running in power modes
//- Clock select 01 enters secondary run
//- Count wraps, sets sticky overflow flag
`ifndef STC_PARAMS_SVH
`define STC_PARAMS_SVH
`define STC_OFF_CONTROL 12'h000
`define STC_OFF_LOW 12'h004
`define STC_OFF_HIGH 12'h008
`define STC_OFF_STATUS 12'h00c
`define STC_OFF_MASK 12'h010
`define STC_OFF_SYSCLK 12'h014
`define STC_OFF_PORT 12'h018
`define STC_BIT_RUN 0
`define STC_BIT_SRC 1
`define STC_BIT_NOSYNC 2
`define STC_BIT_OSCEN 3
`define STC_BIT_PS_LO 4
`define STC_BIT_PS_HI 5
`define STC_BIT_SECRUN 6
`define STC_BIT_WIDE 7
`define STC_CTRL_RESET 8'h00
`define STC_CTRL_WMASK 8'hbf
`define STC_SYSCLK_SEC 2'h1
`define STC_FOSC_MHZ 100
`define STC_INSTR_DIV 4
`define STC_INSTR_CYCLES (`STC_INSTR_DIV)
`endif

// [stc_pkg.sv]
// Types for the sixteen-bit timer/counter
package stc_pkg;
  // Operating mode derived from source and sync bits
  typedef enum logic [1:0] {
    STC_MODE_TIMER = 2'b00,
    STC_MODE_SYNC_CNT = 2'b01,
    STC_MODE_ASYNC_CNT = 2'b10
  } stc_mode_t;
endpackage : stc_pkg

// [stc_prescaler.sv]
// Input prescaler dividing count ticks by 1, 2, 4 or 8
`timescale 1ns/1ps
module stc_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick_in,
  input wire logic clear,
  input wire logic [1:0] ratio_sel,
  output logic tick_out
);
  logic [2:0] count; // Ticks seen in current period
  logic [2:0] limit; // Last count value of the period

  // Limit from ratio: 00->0, 01->1, 10->3, 11->7
  always_comb begin
    limit = 3'h0;
    if (ratio_sel == 2'h1) begin
      limit = 3'h1;
    end else if (ratio_sel == 2'h2) begin
      limit = 3'h3;
    end else if (ratio_sel == 2'h3) begin
      limit = 3'h7;
    end
  end

  assign tick_out = tick_in && (count >= limit);

  // Count ticks; clear wins since a low-byte write restarts the period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 3'h0;
    end else if (clear) begin
      count <= 3'h0;
    end else if (tick_out) begin
      count <= 3'h0;
    end else if (tick_in) begin
      count <= count + 3'h1;
    end
  end
endmodule : stc_prescaler

// [stc_edge_sync.sv]
// External clock input conditioning: optional two-stage sync and rising-edge detect
`timescale 1ns/1ps
module stc_edge_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ext_clk,
  input wire logic bypass,
  output logic rise
);
  logic stage1; // First synchroniser flop, read only by stage2
  logic stage2; // Synchronised level
  logic prev_sync; // Previous synchronised level
  logic prev_raw; // Previous raw level for the unsynchronised path

  // Synchroniser chain and history flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      prev_sync <= 1'b0;
      prev_raw <= 1'b0;
    end else begin
      stage1 <= ext_clk;
      stage2 <= stage1;
      prev_sync <= stage2;
      prev_raw <= ext_clk;
    end
  end

  // Unsynchronised path trades metastability margin for two cycles less latency
  assign rise = bypass ? (ext_clk && !prev_raw) : (stage2 && !prev_sync);
endmodule : stc_edge_sync

// [stc_timer.sv]
// Sixteen-bit timer/counter with APB registers, prescaler and overflow interrupt
`timescale 1ns/1ps
`include "stc_params.svh"
module stc_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_clk_in,
  input wire logic osc_in_pin,
  input wire logic osc_out_pin,
  input wire logic [1:0] port_direction_bits,
  input wire logic [1:0] port_out_bits,
  input wire logic power_managed,
  output logic [1:0] osc_pin_oe,
  output logic [1:0] osc_pin_out,
  output logic osc_running,
  output logic secondary_run_mode,
  output logic [1:0] system_clock_sel,
  output logic irq
);
  logic [7:0] count_unit_control; // Control register, bit 6 is hardware status
  logic [7:0] count_low_byte; // Counter low byte
  logic [7:0] count_high; // Real counter high byte
  logic [7:0] count_high_buffer; // High byte buffer for wide access
  logic overflow_flag; // Sticky overflow status
  logic overflow_irq_enable; // Interrupt mask
  logic [1:0] instr_phase; // Divides pclk into instruction cycles
  logic instr_tick; // One pulse per instruction cycle
  logic ext_rise; // Conditioned external edge
  logic raw_tick; // Selected source before prescaler
  logic pre_tick; // Tick after prescaler
  logic wr_en; // APB write access phase
  logic rd_en; // APB read access phase
  logic wr_low; // Write to low byte
  logic wr_high; // Write to high address
  logic rd_low; // Read of low byte
  logic addr_ok; // Address is mapped
  logic [7:0] wbyte; // Write data low byte
  logic wrap; // Counter wraps this cycle
  logic counter_run_enable; // Run enable field
  logic wide_access_mode; // Wide access field
  logic clock_source_sel; // Clock source field
  logic ext_sync_disable; // Sync bypass field
  logic low_freq_osc_enable; // Oscillator enable field
  logic [1:0] input_prescale_sel; // Prescale field
  logic [7:0] next_high; // High byte after a low-byte write
  stc_pkg::stc_mode_t mode; // Decoded operating mode

  // Address match helper used by several decoders
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    addr_is = (a == off);
  endfunction : addr_is

  assign counter_run_enable = count_unit_control[`STC_BIT_RUN];
  assign clock_source_sel = count_unit_control[`STC_BIT_SRC];
  assign ext_sync_disable = count_unit_control[`STC_BIT_NOSYNC];
  assign low_freq_osc_enable = count_unit_control[`STC_BIT_OSCEN];
  assign input_prescale_sel = count_unit_control[`STC_BIT_PS_HI:`STC_BIT_PS_LO];
  assign wide_access_mode = count_unit_control[`STC_BIT_WIDE];

  // Mode decode, sync bit only matters for the external source
  always_comb begin
    if (!clock_source_sel) begin
      mode = stc_pkg::STC_MODE_TIMER;
    end else if (ext_sync_disable) begin
      mode = stc_pkg::STC_MODE_ASYNC_CNT;
    end else begin
      mode = stc_pkg::STC_MODE_SYNC_CNT;
    end
  end

  // APB: zero wait states, error on unmapped addresses
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign wbyte = pwdata[7:0];
  assign wr_low = wr_en && addr_is(paddr, `STC_OFF_LOW);
  assign wr_high = wr_en && addr_is(paddr, `STC_OFF_HIGH);
  assign rd_low = rd_en && addr_is(paddr, `STC_OFF_LOW);

  // Address map check
  always_comb begin
    if (addr_is(paddr, `STC_OFF_CONTROL)) begin
      addr_ok = 1'b1;
    end else if (addr_is(paddr, `STC_OFF_LOW) || addr_is(paddr, `STC_OFF_HIGH)) begin
      addr_ok = 1'b1;
    end else if (addr_is(paddr, `STC_OFF_STATUS) || addr_is(paddr, `STC_OFF_MASK)) begin
      addr_ok = 1'b1;
    end else if (addr_is(paddr, `STC_OFF_SYSCLK) || addr_is(paddr, `STC_OFF_PORT)) begin
      addr_ok = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end
  assign pslverr = psel && penable && !addr_ok;

  // Instruction cycle is a quarter of the oscillator rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_phase <= 2'h0;
    end else begin
      instr_phase <= instr_phase + 2'h1;
    end
  end
  assign instr_tick = (instr_phase == 2'(`STC_INSTR_CYCLES - 1));

  // External edges come from the pin, or from the oscillator when enabled
  stc_edge_sync u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .ext_clk(low_freq_osc_enable ? osc_in_pin : ext_clk_in),
    .bypass(ext_sync_disable),
    .rise(ext_rise)
  );

  // Source select, gated by run enable
  assign raw_tick = counter_run_enable && (clock_source_sel ? ext_rise : instr_tick);

  stc_prescaler u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(raw_tick),
    .clear(wr_low),
    .ratio_sel(input_prescale_sel),
    .tick_out(pre_tick)
  );

  assign wrap = pre_tick && (count_low_byte == 8'hff) && (count_high == 8'hff);
  assign next_high = wide_access_mode ? count_high_buffer : count_high;

  // Control register; status bit 6 tracks secondary clock use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_unit_control <= `STC_CTRL_RESET;
    end else begin
      if (wr_en && addr_is(paddr, `STC_OFF_CONTROL)) begin
        count_unit_control <= (wbyte & `STC_CTRL_WMASK) | (count_unit_control & ~`STC_CTRL_WMASK);
      end
      count_unit_control[`STC_BIT_SECRUN] <= secondary_run_mode;
    end
  end

  // Low byte: software write wins, else counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_low_byte <= 8'h00;
    end else if (wr_low) begin
      count_low_byte <= wbyte;
    end else if (pre_tick) begin
      count_low_byte <= count_low_byte + 8'h01;
    end
  end

  // Real high byte: wide mode loads from buffer on low write, byte mode direct
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_high <= 8'h00;
    end else if (wr_low) begin
      count_high <= next_high;
    end else if (wr_high && !wide_access_mode) begin
      count_high <= wbyte;
    end else if (pre_tick && (count_low_byte == 8'hff)) begin
      count_high <= count_high + 8'h01;
    end
  end

  // High buffer: written at high address, latched on low read in wide mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_high_buffer <= 8'h00;
    end else if (wr_high && wide_access_mode) begin
      count_high_buffer <= wbyte;
    end else if (rd_low && wide_access_mode) begin
      count_high_buffer <= count_high;
    end
  end

  // Sticky overflow; set beats a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
    end else if (wrap) begin
      overflow_flag <= 1'b1;
    end else if (wr_en && addr_is(paddr, `STC_OFF_STATUS) && wbyte[0]) begin
      overflow_flag <= 1'b0;
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq_enable <= 1'b0;
    end else if (wr_en && addr_is(paddr, `STC_OFF_MASK)) begin
      overflow_irq_enable <= wbyte[0];
    end
  end
  assign irq = overflow_flag && overflow_irq_enable;

  // System clock select; 01 routes system clock from the counter oscillator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_clock_sel <= 2'h0;
    end else if (wr_en && addr_is(paddr, `STC_OFF_SYSCLK)) begin
      system_clock_sel <= wbyte[1:0];
    end
  end
  assign secondary_run_mode = (system_clock_sel == `STC_SYSCLK_SEC);

  // Oscillator stays on in power-managed modes; only the enable bit stops it
  assign osc_running = low_freq_osc_enable;

  // Pin control: enabled counter forces both pins to inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_pin_oe <= 2'h0;
      osc_pin_out <= 2'h0;
    end else begin
      osc_pin_oe <= counter_run_enable ? 2'h0 : ~port_direction_bits;
      osc_pin_out <= port_out_bits;
    end
  end

  // Read mux, combinational via direct decode; byte-mode high reads counter
  always_comb begin
    prdata = 32'h0;
    if (!rd_en) begin
      prdata = 32'h0;
    end else if (addr_is(paddr, `STC_OFF_CONTROL)) begin
      prdata = {24'h0, count_unit_control};
    end else if (addr_is(paddr, `STC_OFF_LOW)) begin
      prdata = {24'h0, count_low_byte};
    end else if (addr_is(paddr, `STC_OFF_HIGH)) begin
      prdata = {24'h0, wide_access_mode ? count_high_buffer : count_high};
    end else if (addr_is(paddr, `STC_OFF_STATUS)) begin
      prdata = {31'h0, overflow_flag};
    end else if (addr_is(paddr, `STC_OFF_MASK)) begin
      prdata = {31'h0, overflow_irq_enable};
    end else if (addr_is(paddr, `STC_OFF_SYSCLK)) begin
      prdata = {30'h0, system_clock_sel};
    end else if (addr_is(paddr, `STC_OFF_PORT)) begin
      prdata = counter_run_enable ? 32'h0 : {30'h0, osc_out_pin, osc_in_pin};
    end
  end

  // Power-managed hint has no effect on the counter clocking
  logic unused_pm; // Keeps the input read
  assign unused_pm = power_managed && (mode == stc_pkg::STC_MODE_ASYNC_CNT);
endmodule : stc_timer

// [stc_timer_properties.sv]
// Port-level checks for the sixteen-bit timer/counter, with shadows of the bus-written control state
`timescale 1ns/1ps
`include "stc_params.svh"
module stc_timer_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [1:0] port_direction_bits,
  input wire logic [1:0] osc_pin_oe,
  input wire logic osc_running,
  input wire logic secondary_run_mode,
  input wire logic [1:0] system_clock_sel,
  input wire logic irq
);
  logic [7:0] ctrl_q; // Control value as software last wrote it
  logic mask_q; // Overflow enable as software last wrote it
  logic wr_acc; // Write access phase
  logic rd_acc; // Read access phase
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  // Shadows move on the completing edge, as the zero-wait slave's registers do
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `STC_CTRL_RESET;
      mask_q <= 1'b0;
    end else if (wr_acc && paddr == `STC_OFF_CONTROL) begin
      ctrl_q <= pwdata[7:0] & `STC_CTRL_WMASK;
    end else if (wr_acc && paddr == `STC_OFF_MASK) begin
      mask_q <= pwdata[0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Two cycles of run enable cover either register stage the pin enables may use
  oe_forced_a: assert property ($past(ctrl_q[0]) && ctrl_q[0] |-> osc_pin_oe == 2'b00)
    else $error("pin enables not forced off while counting");
  oe_follow_a: assert property ($past(presetn) && !$past(ctrl_q[0]) && !ctrl_q[0] && $stable(port_direction_bits)
    |-> osc_pin_oe == ~port_direction_bits)
    else $error("pin enables do not follow direction bits");
  osc_run_a: assert property (osc_running == ctrl_q[3])
    else $error("oscillator state differs from enable bit");
  secrun_a: assert property (secondary_run_mode == (system_clock_sel == `STC_SYSCLK_SEC))
    else $error("secondary run mode wrong for clock select");
  sysclk_wr_a: assert property (wr_acc && paddr == `STC_OFF_SYSCLK |=> system_clock_sel == $past(pwdata[1:0]))
    else $error("clock select not loaded by write");
  status_bit_a: assert property (rd_acc && paddr == `STC_OFF_CONTROL |-> prdata[6] == $past(secondary_run_mode))
    else $error("clock status bit wrong");
  ctrl_read_a: assert property (rd_acc && paddr == `STC_OFF_CONTROL |-> (prdata[7:0] & `STC_CTRL_WMASK) == ctrl_q)
    else $error("control read back differs");
  port_zero_a: assert property (rd_acc && paddr == `STC_OFF_PORT && ctrl_q[0] |-> prdata == 32'h0)
    else $error("pin read not zero while counting");
  unmapped_a: assert property (psel && penable && paddr > `STC_OFF_PORT |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  irq_mask_a: assert property (!mask_q |-> !irq)
    else $error("interrupt raised while masked");
  cover property (wr_acc && paddr == `STC_OFF_LOW && ctrl_q[7]);
  cover property ($rose(irq));
  cover property (rd_acc && paddr == `STC_OFF_PORT && ctrl_q[0]);
endmodule : stc_timer_properties

// [tb_stc_timer.sv]
// Self-checking bench for the sixteen-bit timer/counter
`timescale 1ns/1ps
`include "stc_params.svh"
module tb_stc_timer;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_clk_in, osc_in_pin, osc_out_pin;
  logic power_managed, osc_running, secondary_run_mode, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, keep;
  logic [1:0] port_direction_bits, port_out_bits, osc_pin_oe, osc_pin_out, system_clock_sel;
  logic [15:0] v; // Count read back in two byte transfers
  int mismatches = 0;
  int comparisons = 0;
  // Rows: address, write data, expected read back
  logic [11:0] ra [6] = '{`STC_OFF_CONTROL, `STC_OFF_MASK, `STC_OFF_SYSCLK, `STC_OFF_CONTROL, `STC_OFF_SYSCLK,
    `STC_OFF_CONTROL};
  logic [31:0] rw [6] = '{32'hff, 32'hff, 32'h1, 32'h0, 32'h2, 32'h0};
  logic [31:0] re [6] = '{32'hbf, 32'h1, 32'h1, 32'h40, 32'h2, 32'h0};
  stc_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clk_in(ext_clk_in), .osc_in_pin(osc_in_pin), .osc_out_pin(osc_out_pin),
    .port_direction_bits(port_direction_bits), .port_out_bits(port_out_bits), .power_managed(power_managed),
    .osc_pin_oe(osc_pin_oe), .osc_pin_out(osc_pin_out), .osc_running(osc_running),
    .secondary_run_mode(secondary_run_mode), .system_clock_sel(system_clock_sel), .irq(irq));
  // Clock, 10 ns period
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Watchdog, well beyond the roughly 1500 cycles the tests need
  initial begin
    #200000;
    mismatches++;
    finish_test();
  end
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : cmp
  // One transfer; the leading edge keeps back-to-back calls from driving twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    cmp(n, e, rdat);
  endtask : rd
  // Count read as two byte transfers; only coherent while stopped
  task automatic cnt;
    apb(1'b0, `STC_OFF_LOW, 32'h0);
    v[7:0] = rdat[7:0];
    apb(1'b0, `STC_OFF_HIGH, 32'h0);
    v[15:8] = rdat[7:0];
  endtask : cnt
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  initial begin
    {psel, penable, pwrite, ext_clk_in, osc_in_pin, osc_out_pin, power_managed} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    port_direction_bits = 2'b11;
    port_out_bits = 2'b00;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 7; a++) rd(12'(a * 4), 32'h0, "reset value");
    for (int i = 0; i < 6; i++) begin
      wr(ra[i], rw[i]);
      rd(ra[i], re[i], "row read back");
    end
    $display("test rows finished");
    // Internal source at every prescale; ticks every 4 cycles for about 258 cycles
    for (int p = 0; p < 4; p++) begin
      wr(`STC_OFF_HIGH, 32'h0);
      wr(`STC_OFF_LOW, 32'h0);
      wr(`STC_OFF_CONTROL, 32'h1 | (p << 4));
      repeat (256) @(posedge pclk);
      wr(`STC_OFF_CONTROL, 32'h0);
      cnt();
      cmp("prescaled count", 32'h1, {31'h0, v >= (65 >> p) - 2 && v <= (65 >> p) + 2});
    end
    apb(1'b0, `STC_OFF_LOW, 32'h0);
    keep = rdat;
    repeat (40) @(posedge pclk);
    rd(`STC_OFF_LOW, keep, "stopped count");
    // Synchronised, unsynchronised and oscillator-pin counting, five rising edges each
    for (int m = 0; m < 3; m++) begin
      wr(`STC_OFF_HIGH, 32'h0);
      wr(`STC_OFF_LOW, 32'h0);
      wr(`STC_OFF_CONTROL, 32'h3 | (m << 2));
      for (int i = 0; i < 10; i++) begin
        repeat (4) @(posedge pclk);
        if (m == 2) osc_in_pin <= ~osc_in_pin;
        else ext_clk_in <= ~ext_clk_in;
      end
      repeat (8) @(posedge pclk);
      wr(`STC_OFF_CONTROL, 32'h0);
      cnt();
      cmp("edge count", 32'h5, {16'h0, v});
    end
    $display("test counting finished");
    // Byte mode reaches the real high byte; wide mode only the buffer
    wr(`STC_OFF_HIGH, 32'h12);
    wr(`STC_OFF_LOW, 32'h34);
    rd(`STC_OFF_HIGH, 32'h12, "byte high");
    wr(`STC_OFF_CONTROL, 32'h80);
    wr(`STC_OFF_HIGH, 32'hab);
    rd(`STC_OFF_HIGH, 32'hab, "buffer read");
    wr(`STC_OFF_CONTROL, 32'h0);
    rd(`STC_OFF_HIGH, 32'h12, "high untouched");
    wr(`STC_OFF_CONTROL, 32'h80);
    wr(`STC_OFF_LOW, 32'hcd);
    wr(`STC_OFF_CONTROL, 32'h0);
    rd(`STC_OFF_HIGH, 32'hab, "high loaded");
    wr(`STC_OFF_HIGH, 32'h77);
    wr(`STC_OFF_CONTROL, 32'h80);
    rd(`STC_OFF_LOW, 32'hcd, "wide low");
    rd(`STC_OFF_HIGH, 32'h77, "latched high");
    $display("test access modes finished");
    // Overflow from FFFE, then mask and clear
    wr(`STC_OFF_CONTROL, 32'h0);
    wr(`STC_OFF_HIGH, 32'hff);
    wr(`STC_OFF_LOW, 32'hfe);
    wr(`STC_OFF_MASK, 32'h1);
    wr(`STC_OFF_CONTROL, 32'h1);
    repeat (20) @(posedge pclk);
    wr(`STC_OFF_CONTROL, 32'h0);
    cmp("irq", 32'h1, {31'h0, irq});
    rd(`STC_OFF_STATUS, 32'h1, "overflow flag");
    wr(`STC_OFF_MASK, 32'h0);
    // The write lands on the completing edge, so look once the register has settled
    @(negedge pclk);
    cmp("irq masked", 32'h0, {31'h0, irq});
    wr(`STC_OFF_MASK, 32'h1);
    wr(`STC_OFF_STATUS, 32'h1);
    @(negedge pclk);
    cmp("irq cleared", 32'h0, {31'h0, irq});
    rd(`STC_OFF_STATUS, 32'h0, "flag cleared");
    rd(12'h01c, 32'h0, "unmapped data");
    cmp("unmapped error", 32'h1, {31'h0, err});
    $display("test overflow finished");
    // Oscillator pins as port, then handed to the counter
    port_direction_bits <= 2'b01;
    port_out_bits <= 2'b10;
    osc_in_pin <= 1'b1;
    osc_out_pin <= 1'b1;
    rd(`STC_OFF_PORT, 32'h3, "pins idle");
    cmp("pin enables", 32'h2, {30'h0, osc_pin_oe});
    cmp("pin data", 32'h2, {30'h0, osc_pin_out});
    wr(`STC_OFF_CONTROL, 32'h1);
    rd(`STC_OFF_PORT, 32'h0, "pins running");
    cmp("pin enables running", 32'h0, {30'h0, osc_pin_oe});
    wr(`STC_OFF_CONTROL, 32'h8);
    power_managed <= 1'b1;
    repeat (5) @(posedge pclk);
    cmp("osc in power mode", 32'h1, {31'h0, osc_running});
    wr(`STC_OFF_CONTROL, 32'h0);
    @(negedge pclk);
    cmp("osc off", 32'h0, {31'h0, osc_running});
    $display("test pins finished");
    finish_test();
  end
endmodule : tb_stc_timer
bind stc_timer stc_timer_properties chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .port_direction_bits(port_direction_bits), .osc_pin_oe(osc_pin_oe), .osc_running(osc_running),
  .secondary_run_mode(secondary_run_mode), .system_clock_sel(system_clock_sel), .irq(irq));
